// ==== rtl/frame_parser_pkg.sv ====
// constants and types shared by the serial frame parser
package frame_parser_pkg;
   localparam logic [7:0]  START_DELIM    = 8'h7e;
   localparam logic [7:0]  TYPE_AT_CMD    = 8'h08;
   localparam logic [7:0]  TYPE_TX_PKT    = 8'h10;
   localparam logic [7:0]  TYPE_TX_EXPL   = 8'h11;
   localparam logic [7:0]  TYPE_TX_STATUS = 8'h8b;
   localparam logic [7:0]  CSUM_GOOD      = 8'hff;
   localparam logic [7:0]  OPT_NO_ACK     = 8'h01;
   // offsets counted from the start delimiter
   localparam int          OFS_TYPE       = 3;
   localparam int          OFS_ID         = 4;
   localparam int          OFS_ADDR_FIRST = 5;
   localparam int          OFS_ADDR_LAST  = 12;
   localparam int          OFS_AT_CMD0    = 5;
   localparam int          OFS_AT_CMD1    = 6;
   localparam int          OFS_AT_PARAM   = 7;
   localparam int          OFS_TX_OPT     = 16;
   localparam int          OFS_TX_DATA    = 17;
   localparam int          OFS_EX_EP      = 16;
   localparam int          OFS_EX_CL_HI   = 17;
   localparam int          OFS_EX_CL_LO   = 18;
   localparam int          OFS_EX_OPT     = 22;
   localparam int          OFS_EX_DATA    = 23;
   localparam int          MAX_PAYLOAD    = 1392;
   localparam logic [47:0] MAC_RESET      = 48'h0;
   typedef enum logic [1:0] {KIND_NONE, KIND_AT, KIND_TX, KIND_EXPL} frame_kind_e;
endpackage

// ==== rtl/payload_mem.sv ====
// payload buffer memory with registered read
`timescale 1ns/1ns
module payload_mem #(
   parameter int DEPTH = 1392,
   parameter int AW    = 11
) (
   // clock
   input  wire logic          clk_sys,
   input  wire logic          ce,
   // write port
   input  wire logic          wr_en,
   input  wire logic [AW-1:0] wr_addr,
   input  wire logic [7:0]    wr_data,
   // read port
   input  wire logic [AW-1:0] rd_addr,
   output logic      [7:0]    rd_data
);
   if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_depth_check
      $error("payload_mem depth exceeds address range");
   end
   logic [7:0] mem [DEPTH];
   always_ff @(posedge clk_sys) begin
      if (ce) begin
         if (wr_en) begin
            mem[wr_addr] <= wr_data;
         end
         rd_data <= mem[rd_addr];
      end
   end
endmodule // payload_mem

// ==== rtl/frame_parser.sv ====
// serial transmit frame parser with status frame generation
`timescale 1ns/1ns
module frame_parser #(
   parameter int MAX_LEN = frame_parser_pkg::MAX_PAYLOAD,
   parameter int AW      = 11
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst,
   input  wire logic        ce,
   // own station address
   input  wire logic [47:0] own_mac,
   // incoming frame bytes
   input  wire logic        rx_valid,
   input  wire logic [7:0]  rx_byte,
   output logic             rx_ready,
   // decoded frame
   output logic             frm_valid,
   output logic [1:0]       frm_kind,
   output logic [7:0]       frm_id,
   output logic [63:0]      frm_addr,
   output logic             frm_addr_is_mac,
   output logic             frm_no_ack,
   output logic [7:0]       frm_opts,
   output logic [7:0]       frm_endpoint,
   output logic [15:0]      frm_cluster,
   output logic [15:0]      frm_at_cmd,
   output logic [10:0]      frm_len,
   output logic             frm_drop,
   // payload readback
   input  wire logic [AW-1:0] pl_rd_addr,
   output logic      [7:0]    pl_rd_data,
   // status frame request
   output logic             stat_valid,
   output logic [7:0]       stat_type,
   output logic [7:0]       stat_id,
   input  wire logic        stat_ready
);
   if (MAX_LEN < 1 || MAX_LEN > (1 << AW) || MAX_LEN > 2047) begin : g_len_check
      $error("frame_parser MAX_LEN out of range");
   end

   // ==========================================================
   // state
   typedef enum logic [2:0] {S_IDLE, S_LEN_HI, S_LEN_LO, S_DATA, S_CSUM, S_STATUS} state_e;
   state_e      st_r, st_nxt;
   logic [15:0] len_r, len_nxt;
   logic [15:0] pos_r, pos_nxt;
   logic [7:0]  sum_r, sum_nxt;
   logic [7:0]  type_r, type_nxt;
   logic [7:0]  id_r, id_nxt;
   logic [63:0] addr_r, addr_nxt;
   logic [7:0]  opt_r, opt_nxt;
   logic [7:0]  ep_r, ep_nxt;
   logic [15:0] cl_r, cl_nxt;
   logic [15:0] at_r, at_nxt;
   logic [10:0] pl_r, pl_nxt;
   logic        ovf_r, ovf_nxt;
   logic        fv_r, fv_nxt;
   logic        fd_r, fd_nxt;
   logic        mac_r, mac_nxt;
   logic        pl_we;
   logic [15:0] ofs;

   function automatic logic [15:0] data_start(input logic [7:0] t);
      case (t)
         frame_parser_pkg::TYPE_AT_CMD:  data_start = 16'(frame_parser_pkg::OFS_AT_PARAM);
         frame_parser_pkg::TYPE_TX_PKT:  data_start = 16'(frame_parser_pkg::OFS_TX_DATA);
         frame_parser_pkg::TYPE_TX_EXPL: data_start = 16'(frame_parser_pkg::OFS_EX_DATA);
         default:                        data_start = 16'hffff;
      endcase
   endfunction

   function automatic logic known(input logic [7:0] t);
      known = (t == frame_parser_pkg::TYPE_AT_CMD) || (t == frame_parser_pkg::TYPE_TX_PKT)
              || (t == frame_parser_pkg::TYPE_TX_EXPL);
   endfunction

   // ==========================================================
   // next state
   always_comb begin
      st_nxt = st_r;
      len_nxt = len_r;
      pos_nxt = pos_r;
      sum_nxt = sum_r;
      type_nxt = type_r;
      id_nxt = id_r;
      addr_nxt = addr_r;
      opt_nxt = opt_r;
      ep_nxt = ep_r;
      cl_nxt = cl_r;
      at_nxt = at_r;
      pl_nxt = pl_r;
      ovf_nxt = ovf_r;
      mac_nxt = mac_r;
      fv_nxt = 1'b0;
      fd_nxt = 1'b0;
      pl_we = 1'b0;
      ofs = pos_r + 16'h0003;
      case (st_r)
         S_IDLE: begin
            if (rx_valid && rx_byte == frame_parser_pkg::START_DELIM) begin
               st_nxt = S_LEN_HI;
            end
         end
         S_LEN_HI: begin
            if (rx_valid) begin
               len_nxt = {rx_byte, 8'h00};
               st_nxt = S_LEN_LO;
            end
         end
         S_LEN_LO: begin
            if (rx_valid) begin
               len_nxt = {len_r[15:8], rx_byte};
               pos_nxt = 16'h0000;
               sum_nxt = 8'h00;
               pl_nxt = 11'h000;
               ovf_nxt = 1'b0;
               addr_nxt = 64'h0;
               opt_nxt = 8'h00;
               ep_nxt = 8'h00;
               cl_nxt = 16'h0000;
               at_nxt = 16'h0000;
               st_nxt = ({len_r[15:8], rx_byte} == 16'h0000) ? S_IDLE : S_DATA;
            end
         end
         S_DATA: begin
            if (rx_valid) begin
               sum_nxt = sum_r + rx_byte;
               pos_nxt = pos_r + 16'h0001;
               if (ofs == 16'(frame_parser_pkg::OFS_TYPE)) type_nxt = rx_byte;
               if (ofs == 16'(frame_parser_pkg::OFS_ID)) id_nxt = rx_byte;
               if (type_r == frame_parser_pkg::TYPE_AT_CMD) begin
                  if (ofs == 16'(frame_parser_pkg::OFS_AT_CMD0)) at_nxt[15:8] = rx_byte;
                  if (ofs == 16'(frame_parser_pkg::OFS_AT_CMD1)) at_nxt[7:0] = rx_byte;
               end else if (ofs >= 16'(frame_parser_pkg::OFS_ADDR_FIRST)
                            && ofs <= 16'(frame_parser_pkg::OFS_ADDR_LAST)) begin
                  addr_nxt = {addr_r[55:0], rx_byte};
               end
               if (type_r == frame_parser_pkg::TYPE_TX_PKT
                   && ofs == 16'(frame_parser_pkg::OFS_TX_OPT)) opt_nxt = rx_byte;
               if (type_r == frame_parser_pkg::TYPE_TX_EXPL) begin
                  if (ofs == 16'(frame_parser_pkg::OFS_EX_EP)) ep_nxt = rx_byte;
                  if (ofs == 16'(frame_parser_pkg::OFS_EX_CL_HI)) cl_nxt[15:8] = rx_byte;
                  if (ofs == 16'(frame_parser_pkg::OFS_EX_CL_LO)) cl_nxt[7:0] = rx_byte;
                  if (ofs == 16'(frame_parser_pkg::OFS_EX_OPT)) opt_nxt = rx_byte;
               end
               // reserved offsets fall through untouched
               if (ofs >= data_start(type_r)) begin
                  if (32'(pl_r) < MAX_LEN) begin
                     pl_we = 1'b1;
                     pl_nxt = pl_r + 11'h001;
                  end else begin
                     ovf_nxt = 1'b1;
                  end
               end
               if (pos_r + 16'h0001 == len_r) st_nxt = S_CSUM;
            end
         end
         S_CSUM: begin
            if (rx_valid) begin
               mac_nxt = (addr_r[47:0] == own_mac);
               if (sum_r + rx_byte == frame_parser_pkg::CSUM_GOOD && known(type_r) && !ovf_r) begin
                  fv_nxt = 1'b1;
                  if (type_r != frame_parser_pkg::TYPE_AT_CMD && id_r != 8'h00) begin
                     st_nxt = S_STATUS;
                  end else begin
                     st_nxt = S_IDLE;
                  end
               end else begin
                  fd_nxt = 1'b1;
                  st_nxt = S_IDLE;
               end
            end
         end
         S_STATUS: begin
            if (stat_ready) st_nxt = S_IDLE;
         end
         default: st_nxt = S_IDLE;
      endcase
   end

   // ==========================================================
   // registers
   always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
         st_r <= S_IDLE;
         len_r <= 16'h0000;
         pos_r <= 16'h0000;
         sum_r <= 8'h00;
         type_r <= 8'h00;
         id_r <= 8'h00;
         addr_r <= 64'h0;
         opt_r <= 8'h00;
         ep_r <= 8'h00;
         cl_r <= 16'h0000;
         at_r <= 16'h0000;
         pl_r <= 11'h000;
         ovf_r <= 1'b0;
         fv_r <= 1'b0;
         fd_r <= 1'b0;
         mac_r <= 1'b0;
      end else if (ce) begin
         st_r <= st_nxt;
         len_r <= len_nxt;
         pos_r <= pos_nxt;
         sum_r <= sum_nxt;
         type_r <= type_nxt;
         id_r <= id_nxt;
         addr_r <= addr_nxt;
         opt_r <= opt_nxt;
         ep_r <= ep_nxt;
         cl_r <= cl_nxt;
         at_r <= at_nxt;
         pl_r <= pl_nxt;
         ovf_r <= ovf_nxt;
         fv_r <= fv_nxt;
         fd_r <= fd_nxt;
         mac_r <= mac_nxt;
      end
   end

   // ==========================================================
   // payload store
   payload_mem #(.DEPTH(MAX_LEN), .AW(AW)) u_mem (
      .clk_sys (clk_sys),
      .ce      (ce),
      .wr_en   (pl_we && ce),
      .wr_addr (AW'(pl_r)),
      .wr_data (rx_byte),
      .rd_addr (pl_rd_addr),
      .rd_data (pl_rd_data)
   );

   // ==========================================================
   // outputs
   assign rx_ready        = (st_r != S_STATUS);
   assign frm_valid       = fv_r;
   assign frm_drop        = fd_r;
   assign frm_kind        = (type_r == frame_parser_pkg::TYPE_AT_CMD)  ? 2'(frame_parser_pkg::KIND_AT) :
                            (type_r == frame_parser_pkg::TYPE_TX_PKT)  ? 2'(frame_parser_pkg::KIND_TX) :
                            (type_r == frame_parser_pkg::TYPE_TX_EXPL) ? 2'(frame_parser_pkg::KIND_EXPL) :
                            2'(frame_parser_pkg::KIND_NONE);
   assign frm_id          = id_r;
   assign frm_addr        = addr_r;
   assign frm_addr_is_mac = mac_r;
   assign frm_opts        = opt_r;
   assign frm_no_ack      = opt_r[0] && (type_r != frame_parser_pkg::TYPE_AT_CMD);
   assign frm_endpoint    = ep_r;
   assign frm_cluster     = cl_r;
   assign frm_at_cmd      = at_r;
   assign frm_len         = pl_r;
   assign stat_valid      = (st_r == S_STATUS);
   assign stat_type       = frame_parser_pkg::TYPE_TX_STATUS;
   assign stat_id         = id_r;
endmodule // frame_parser

// ==== tb/frame_parser_sva.sv ====
// checker for the frame parser output side
`timescale 1ns/1ns
module frame_parser_sva #(
   parameter int MAX_LEN = 1392
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst,
   // watched signals
   input wire logic [47:0] own_mac,
   input wire logic        rx_ready,
   input wire logic        frm_valid,
   input wire logic [1:0]  frm_kind,
   input wire logic [7:0]  frm_id,
   input wire logic [63:0] frm_addr,
   input wire logic        frm_addr_is_mac,
   input wire logic        frm_no_ack,
   input wire logic [7:0]  frm_opts,
   input wire logic [10:0] frm_len,
   input wire logic        frm_drop,
   input wire logic        stat_valid,
   input wire logic [7:0]  stat_type,
   input wire logic [7:0]  stat_id,
   input wire logic        stat_ready
);
   // ==========================================
   // properties
   default clocking @(posedge clk_sys); endclocking
   default disable iff (rst);
   a_status_code: assert property (stat_type == 8'h8b)
      else $error("status type wrong");
   a_status_hold: assert property (stat_valid && !stat_ready |=> stat_valid && $stable(stat_id))
      else $error("status dropped early");
   a_status_id: assert property (frm_valid && stat_valid |-> stat_id == frm_id)
      else $error("status id mismatch");
   a_status_due: assert property (frm_valid && frm_id != 8'h00 && frm_kind[1] |-> stat_valid)
      else $error("status missing");
   a_status_cause: assert property ($rose(stat_valid) |-> frm_valid && frm_id != 8'h00)
      else $error("status without cause");
   a_zero_quiet: assert property (frm_valid && frm_id == 8'h00 |-> !stat_valid)
      else $error("status for zero id");
   a_mac_select: assert property (frm_valid |-> frm_addr_is_mac == (frm_addr[47:0] == own_mac))
      else $error("mac flag wrong");
   a_noack_bit: assert property (frm_valid && frm_kind[1] |-> frm_no_ack == frm_opts[0])
      else $error("no ack flag wrong");
   a_len_limit: assert property (frm_valid |-> frm_len <= MAX_LEN)
      else $error("payload too long");
   a_one_verdict: assert property (frm_valid |-> !frm_drop ##1 !frm_valid && !frm_drop)
      else $error("verdict not a single pulse");
   a_ready_status: assert property (stat_valid |-> !rx_ready)
      else $error("bytes taken during status");
endmodule // frame_parser_sva

// ==== tb/frame_host.sv ====
// host model sending serial frames into the parser
`timescale 1ns/1ns
module frame_host (
   // clock
   input  wire logic  clk_sys,
   // byte stream
   output logic       rx_valid,
   output logic [7:0] rx_byte,
   input  wire logic  rx_ready,
   // status handshake
   output logic       stat_ready
);
   // ==========================================
   // frame and status tasks
   initial begin
      rx_valid = 1'b0;
      rx_byte = 8'h00;
      stat_ready = 1'b0;
   end
   // ready is looked at mid-cycle, where it is settled, and holds up to the next edge
   task automatic put(input logic [7:0] b);
      logic rdy;
      rx_valid <= 1'b1;
      rx_byte <= b;
      do begin
         @(negedge clk_sys);
         rdy = rx_ready;
         @(posedge clk_sys);
      end while (rdy !== 1'b1);
   endtask
   // delimiter, big-endian length, data, checksum; bad flips it
   task automatic send(input logic [7:0] d[$], input logic bad);
      logic [7:0] s;
      s = 8'hff;
      @(posedge clk_sys);
      put(8'h7e);
      put(8'(d.size() >> 8));
      put(8'(d.size()));
      foreach (d[i]) begin
         put(d[i]);
         s = s - d[i];
      end
      put(bad ? ~s : s);
      rx_valid <= 1'b0;
      rx_byte <= ~rx_byte;
   endtask
   task automatic ack(input int n);
      repeat (n) @(posedge clk_sys);
      stat_ready <= 1'b1;
      @(posedge clk_sys);
      stat_ready <= 1'b0;
   endtask
endmodule // frame_host

// ==== tb/frame_parser_tb.sv ====
// self-checking bench for the frame parser
`timescale 1ns/1ns
`define CHK(n, e, s) begin checks++; if ((s) !== (e)) begin failures++; \
   $display("[ERR] %s exp %0h got %0h", n, e, s); end end
module frame_parser_tb;
   // ==========================================
   // signals and instances
   logic        clk_sys, rst, rx_valid, rx_ready, frm_valid, frm_drop, stat_valid;
   logic        frm_addr_is_mac, frm_no_ack, stat_ready, ce;
   logic [47:0] own_mac;
   logic [7:0]  rx_byte, frm_id, frm_opts, frm_endpoint, pl_rd_data, stat_type, stat_id, v;
   logic [1:0]  frm_kind;
   logic [63:0] frm_addr;
   logic [15:0] frm_cluster, frm_at_cmd;
   logic [10:0] frm_len, pl_rd_addr;
   logic [7:0]  d[$];
   int          failures, checks;
   frame_parser u_frame_parser (.clk_sys, .rst, .ce, .own_mac, .rx_valid, .rx_byte,
      .rx_ready, .frm_valid, .frm_kind, .frm_id, .frm_addr, .frm_addr_is_mac, .frm_no_ack,
      .frm_opts, .frm_endpoint, .frm_cluster, .frm_at_cmd, .frm_len, .frm_drop, .pl_rd_addr,
      .pl_rd_data, .stat_valid, .stat_type, .stat_id, .stat_ready);
   frame_host u_frame_host (.clk_sys, .rx_valid, .rx_byte, .rx_ready, .stat_ready);
   // ==========================================
   // scenarios
   task automatic rd(input logic [10:0] a);
      @(posedge clk_sys);
      pl_rd_addr <= a;
      @(posedge clk_sys);
      #1 v = pl_rd_data;
   endtask
   task automatic go(input logic bad);
      u_frame_host.send(d, bad);
      #1;
   endtask
   task automatic t_at();
      d = {8'h08, 8'h01, 8'h4e, 8'h49};
      go(1'b0);
      `CHK("at kind", 2'h1, frm_kind)
      `CHK("at cmd", 16'h4e49, frm_at_cmd)
      `CHK("at status", 1'b0, stat_valid)
   endtask
   task automatic t_tx();
      d = {8'h10, 8'ha5, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h01, 8'h82, 8'hff, 8'hfe,
           8'he6, 8'h00, 8'h48, 8'h65, 8'h6c, 8'h6c, 8'h6f};
      go(1'b0);
      `CHK("tx kind", 2'h2, frm_kind)
      `CHK("tx addr", 64'h00000000c0a80182, frm_addr)
      `CHK("tx mac", 1'b0, frm_addr_is_mac)
      `CHK("tx len", 11'h005, frm_len)
      `CHK("tx status", 1'b1, stat_valid)
      `CHK("tx stat id", 8'ha5, stat_id)
      `CHK("tx stat type", 8'h8b, stat_type)
      `CHK("tx id", 8'ha5, frm_id)
      `CHK("tx no ack", 1'b0, frm_no_ack)
      @(posedge clk_sys);
      ce <= 1'b0;
      u_frame_host.ack(1);
      #1;
      `CHK("ce freeze", 1'b1, stat_valid)
      @(posedge clk_sys);
      ce <= 1'b1;
      u_frame_host.ack(3);
      #1;
      `CHK("status end", 1'b0, stat_valid)
      rd(11'h004);
      `CHK("tx data", 8'h6f, v)
   endtask
   task automatic t_expl();
      d = {8'h11, 8'h00, 8'h00, 8'h00, 8'h0a, 8'h1b, 8'h2c, 8'h3d, 8'h4e, 8'h5f, 8'h12, 8'h34,
           8'h56, 8'he6, 8'h00, 8'h23, 8'hc1, 8'h05, 8'h77, 8'h01, 8'h9a, 8'hbc};
      go(1'b0);
      `CHK("ex kind", 2'h3, frm_kind)
      `CHK("ex endpoint", 8'he6, frm_endpoint)
      `CHK("ex cluster", 16'h0023, frm_cluster)
      `CHK("ex no ack", 1'b1, frm_no_ack)
      `CHK("ex mac", 1'b1, frm_addr_is_mac)
      `CHK("ex status", 1'b0, stat_valid)
      rd(11'h000);
      `CHK("ex data", 8'h9a, v)
   endtask
   task automatic t_bad();
      d = {8'h08, 8'h01, 8'h4e, 8'h49};
      go(1'b1);
      `CHK("bad sum", 1'b1, frm_drop)
      d = {8'h17, 8'h01, 8'h44, 8'h4c};
      go(1'b0);
      `CHK("bad type", 1'b1, frm_drop)
   endtask
   task automatic t_max();
      d = {8'h10, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 8'ha8, 8'h00, 8'h64, 8'h00, 8'h00,
           8'h00, 8'h01};
      repeat (1391) d.push_back(8'h3c);
      d.push_back(8'hc3);
      go(1'b0);
      `CHK("max valid", 1'b1, frm_valid)
      `CHK("max len", 11'h570, frm_len)
      rd(11'h56f);
      `CHK("max last", 8'hc3, v)
      d.push_back(8'h3c);
      go(1'b0);
      `CHK("over drop", 1'b1, frm_drop)
   endtask
   task automatic summarize();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // ==========================================
   // clock, watchdog and sequence
   initial begin
      clk_sys = 1'b0;
      forever #20 clk_sys = ~clk_sys;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      failures++;
      summarize();
   end
   initial begin
      rst = 1'b1;
      ce = 1'b1;
      own_mac = 48'h0a1b2c3d4e5f;
      pl_rd_addr = 11'h000;
      repeat (16) @(posedge clk_sys);
      rst <= 1'b0;
      t_at();
      t_tx();
      t_expl();
      t_bad();
      t_max();
      summarize();
   end
endmodule // frame_parser_tb
bind frame_parser frame_parser_sva #(.MAX_LEN(MAX_LEN)) u_frame_parser_sva (.clk_sys, .rst,
   .own_mac, .rx_ready, .frm_valid, .frm_kind, .frm_id, .frm_addr, .frm_addr_is_mac,
   .frm_no_ack, .frm_opts, .frm_len, .frm_drop, .stat_valid, .stat_type, .stat_id, .stat_ready);
